//--- design/hltmc_mode_ctrl.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "hltmc_params.svh"
// Behaviour
// - external reset input picked by source-select register; starts, stops, clears count
// - 5-bit mode; upper 00 free, 01 one-shot, 10 mono/level, 11 reserved
// - external trigger activity ignored during debug freeze
// - software gate counts while run bit set, holds otherwise
// - free modes: count equal period returns to zero next clock
// - active-high gate counts while run and input high
// - active-low gate counts while run and input low
// - edge-reset modes clear count on any, rising or falling edge
// - level-reset modes hold count clear on low or high level
// - software one-shot starts when run bit set
// - one-shot match clears run bit, stops counter at zero
// - edge-start modes need run bit plus selected edge
// - after run bit drops, fresh edge needed to resume
// - edge-start edge-reset one-shot: first edge starts, later edges clear
// - one-shot 110/111 edge start with opposite level holding clear
// - monostable match stops at zero, run bit stays set
// - level-start one-shot starts on level, clears on opposite level
// - period flag when postscaler count hits 4-bit ratio
// - period interrupt forwarded only while enable bit set
// - run bit and input synchronised over two timer clocks
// - postscaler match gives one-clock pulse and clears postscaler
// - postscaler cleared on count write, control write, reset, ext clear
// - reset clears count and sets period to all ones
module hltmc_mode_ctrl #(
  parameter int SRC_N = 8,
  parameter int SRC_W = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input hltmc_pkg::hltmc_bus_s bus_i,
  output logic [7:0] rdata_o,
  // external reset candidates and debug
  input wire logic [SRC_N-1:0] ext_reset_input_i,
  input wire logic debug_freeze_i,
  // timer outputs
  output logic [7:0] count_value_o,
  output logic postscaled_pulse_out_o,
  output logic period_irq_o
);
  import hltmc_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] count_ff, period_ff, nxt_count;
  logic on_ff;
  logic [2:0] pre_sel_ff;
  logic [3:0] post_sel_ff, post_cnt_ff;
  logic [4:0] mode_ff;
  logic [SRC_W-1:0] src_sel_ff;
  logic irq_en_ff, irq_flag_ff;
  logic armed_ff, done_ff;
  logic run_s1_ff, run_s2_ff;
  logic ers_s1_ff, ers_s2_ff, ers_hold_ff, ers_prev_ff;

  logic wr_count, wr_ctrl, match, go, clr, clr_evt, hw_stop;
  logic os_clr_on, arm_set, start_edge, rst_edge;
  logic ers_lvl, ers_rise, ers_fall, post_hit;
  logic [2:0] sub;
  hltmc_grp_e grp;

  assign grp = hltmc_grp_e'(mode_ff[4:3]);
  assign sub = mode_ff[2:0];
  assign wr_count = bus_i.wr && bus_i.addr == `HLTMC_OFS_COUNT;
  assign wr_ctrl = bus_i.wr && bus_i.addr == `HLTMC_OFS_CTRL;
  assign match = count_ff == period_ff;

  // ---------------------------------------------------------------
  // external input selection and synchronisation
  // ---------------------------------------------------------------
  // source select
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ers_s1_ff <= 1'b0;
      ers_s2_ff <= 1'b0;
      run_s1_ff <= 1'b0;
      run_s2_ff <= 1'b0;
    end else begin
      ers_s1_ff <= ext_reset_input_i[src_sel_ff];
      ers_s2_ff <= ers_s1_ff;
      run_s1_ff <= on_ff;
      run_s2_ff <= run_s1_ff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ers_hold_ff <= 1'b0;
      ers_prev_ff <= 1'b0;
    end else begin
      if (!debug_freeze_i)
        ers_hold_ff <= ers_s2_ff;
      ers_prev_ff <= ers_hold_ff;
    end
  end

  assign ers_lvl = ers_hold_ff;
  assign ers_rise = !debug_freeze_i && ers_hold_ff && !ers_prev_ff;
  assign ers_fall = !debug_freeze_i && !ers_hold_ff && ers_prev_ff;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // mode groups
  always_comb begin
    go = 1'b0;
    clr = 1'b0;
    start_edge = 1'b0;
    rst_edge = 1'b0;
    case (grp)
      HLTMC_GRP_FREE: begin
        case (sub)
          3'b000: go = run_s2_ff;
          3'b001: go = run_s2_ff && ers_lvl;
          3'b010: go = run_s2_ff && !ers_lvl;
          3'b011: begin
            go = run_s2_ff;
            clr = run_s2_ff && (ers_rise || ers_fall);
          end
          3'b100: begin
            go = run_s2_ff;
            clr = run_s2_ff && ers_rise;
          end
          3'b101: begin
            go = run_s2_ff;
            clr = run_s2_ff && ers_fall;
          end
          3'b110: begin
            clr = !ers_lvl;
            go = run_s2_ff && ers_lvl;
          end
          default: begin
            clr = ers_lvl;
            go = run_s2_ff && !ers_lvl;
          end
        endcase
      end
      HLTMC_GRP_ONESHOT: begin
        case (sub)
          3'b000: go = run_s2_ff && !done_ff;
          3'b001: start_edge = ers_rise;
          3'b010: start_edge = ers_fall;
          3'b011: start_edge = ers_rise || ers_fall;
          3'b100: begin
            start_edge = ers_rise;
            rst_edge = ers_rise;
          end
          3'b101: begin
            start_edge = ers_fall;
            rst_edge = ers_fall;
          end
          3'b110: begin
            start_edge = ers_rise;
            clr = !ers_lvl;
          end
          default: begin
            start_edge = ers_fall;
            clr = ers_lvl;
          end
        endcase
        if (sub != 3'b000)
          go = run_s2_ff && armed_ff && !clr;
        if (armed_ff && rst_edge && run_s2_ff)
          clr = 1'b1;
      end
      HLTMC_GRP_MONO: begin
        case (sub)
          3'b001: start_edge = ers_rise;
          3'b010: start_edge = ers_fall;
          3'b011: start_edge = ers_rise || ers_fall;
          3'b110: begin
            go = run_s2_ff && ers_lvl && !done_ff;
            clr = !ers_lvl;
          end
          3'b111: begin
            go = run_s2_ff && !ers_lvl && !done_ff;
            clr = ers_lvl;
          end
          default: go = 1'b0;
        endcase
        if (sub == 3'b001 || sub == 3'b010 || sub == 3'b011)
          go = run_s2_ff && armed_ff;
      end
      default: go = 1'b0;
    endcase
  end

  assign os_clr_on = go && match && (grp == HLTMC_GRP_ONESHOT ||
    (grp == HLTMC_GRP_MONO && sub[2:1] == 2'b11));
  assign hw_stop = go && match && grp != HLTMC_GRP_FREE;
  assign arm_set = run_s2_ff && start_edge && !done_ff;
  assign clr_evt = clr && count_ff != 8'h00;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // wrap at period
  // count write wins so the output copy tracks the register
  always_comb begin
    nxt_count = count_ff;
    if (wr_count)
      nxt_count = bus_i.wdata;
    else if (clr)
      nxt_count = 8'h00;
    else if (go)
      nxt_count = match ? 8'h00 : 8'(count_ff + 8'h01);
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      count_ff <= `HLTMC_RST_COUNT;
    else
      count_ff <= nxt_count;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      armed_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (!run_s2_ff || hw_stop)
        armed_ff <= 1'b0;
      else if (arm_set)
        armed_ff <= 1'b1;
      if (!run_s2_ff)
        done_ff <= 1'b0;
      else if (os_clr_on)
        done_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // postscaler and interrupt
  // ---------------------------------------------------------------
  assign post_hit = go && match && post_cnt_ff == post_sel_ff;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      post_cnt_ff <= 4'h0;
      postscaled_pulse_out_o <= 1'b0;
    end else begin
      postscaled_pulse_out_o <= post_hit;
      if (wr_count || wr_ctrl || clr_evt || post_hit)
        post_cnt_ff <= 4'h0;
      else if (go && match)
        post_cnt_ff <= 4'(post_cnt_ff + 4'h1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_flag_ff <= 1'b0;
      period_irq_o <= 1'b0;
    end else begin
      if (post_hit)
        irq_flag_ff <= 1'b1;
      else if (bus_i.wr && bus_i.addr == `HLTMC_OFS_STAT &&
               bus_i.wdata[0])
        irq_flag_ff <= 1'b0;
      period_irq_o <= irq_flag_ff && irq_en_ff;
    end
  end

  // ---------------------------------------------------------------
  // register writes and reads
  // ---------------------------------------------------------------
  // hardware clears run bit
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      period_ff <= `HLTMC_RST_PERIOD;
      on_ff <= 1'b0;
      pre_sel_ff <= 3'h0;
      post_sel_ff <= 4'h0;
      mode_ff <= `HLTMC_RST_MODE;
      src_sel_ff <= '0;
      irq_en_ff <= 1'b0;
    end else begin
      if (bus_i.wr && bus_i.addr == `HLTMC_OFS_PERIOD)
        period_ff <= bus_i.wdata;
      if (wr_ctrl) begin
        on_ff <= bus_i.wdata[`HLTMC_CTRL_ON];
        pre_sel_ff <=
          bus_i.wdata[`HLTMC_CTRL_PRE_HI:`HLTMC_CTRL_PRE_LO];
        post_sel_ff <=
          bus_i.wdata[`HLTMC_CTRL_POST_HI:`HLTMC_CTRL_POST_LO];
      end else if (os_clr_on) begin
        on_ff <= 1'b0;
      end
      if (bus_i.wr && bus_i.addr == `HLTMC_OFS_HLT)
        mode_ff <= bus_i.wdata[4:0];
      if (bus_i.wr && bus_i.addr == `HLTMC_OFS_SRC)
        src_sel_ff <= bus_i.wdata[SRC_W-1:0];
      if (bus_i.wr && bus_i.addr == `HLTMC_OFS_IRQEN)
        irq_en_ff <= bus_i.wdata[0];
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
      count_value_o <= 8'h00;
    end else begin
      count_value_o <= nxt_count;
      rdata_o <= 8'h00;
      if (bus_i.rd) begin
        case (bus_i.addr)
          `HLTMC_OFS_COUNT: rdata_o <= count_ff;
          `HLTMC_OFS_PERIOD: rdata_o <= period_ff;
          `HLTMC_OFS_CTRL: rdata_o <= {on_ff, pre_sel_ff, post_sel_ff};
          `HLTMC_OFS_HLT: rdata_o <= {3'h0, mode_ff};
          `HLTMC_OFS_SRC: rdata_o <= 8'(src_sel_ff);
          `HLTMC_OFS_IRQEN: rdata_o <= {7'h00, irq_en_ff};
          `HLTMC_OFS_STAT:
            rdata_o <= {4'h0, ers_lvl, done_ff, armed_ff, irq_flag_ff};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // software gate advances by one
  property p_sw_gate;
    @(posedge sys_clk_i) disable iff (srst_i)
    (mode_ff == 5'h00 && run_s2_ff && !match && !wr_count)
      |=> count_ff == 8'($past(count_ff) + 8'h01);
  endproperty
  a_sw_gate: assert property (p_sw_gate)
    else $error("software gate did not advance");

  // free mode wraps to zero
  property p_wrap;
    @(posedge sys_clk_i) disable iff (srst_i)
    (grp == HLTMC_GRP_FREE && go && match && !wr_count)
      |=> count_ff == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("free mode did not wrap");

  // one-shot match drops run bit
  property p_os_stop;
    @(posedge sys_clk_i) disable iff (srst_i)
    (grp == HLTMC_GRP_ONESHOT && go && match && !wr_ctrl && !wr_count)
      |=> !on_ff && count_ff == 8'h00 ##1 !go [*2];
  endproperty
  a_os_stop: assert property (p_os_stop)
    else $error("one-shot did not stop");

  // monostable keeps run bit
  property p_mono_stop;
    @(posedge sys_clk_i) disable iff (srst_i)
    (mode_ff[4:2] == 3'b100 && go && match && !wr_ctrl && !wr_count)
      |=> on_ff && count_ff == 8'h00 && !armed_ff;
  endproperty
  a_mono_stop: assert property (p_mono_stop)
    else $error("monostable stop wrong");

  // level reset holds zero
  property p_lvl_rst;
    @(posedge sys_clk_i) disable iff (srst_i)
    (mode_ff == 5'h06 && !ers_lvl && !wr_count) |=> count_ff == 8'h00;
  endproperty
  a_lvl_rst: assert property (p_lvl_rst)
    else $error("level reset did not clear");

  // no edges while frozen
  property p_freeze;
    @(posedge sys_clk_i) disable iff (srst_i)
    debug_freeze_i |-> !ers_rise && !ers_fall && !arm_set
      ##1 $stable(ers_lvl);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("edge seen during freeze");

  // run bit seen two clocks later
  property p_sync;
    @(posedge sys_clk_i) disable iff (srst_i)
    !$past(srst_i, 2) |-> run_s2_ff == $past(on_ff, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("run sync delay wrong");

  // pulse and postscaler clear together
  property p_post;
    @(posedge sys_clk_i) disable iff (srst_i)
    post_hit |=> postscaled_pulse_out_o && post_cnt_ff == 4'h0
      && irq_flag_ff;
  endproperty
  a_post: assert property (p_post)
    else $error("postscaler pulse wrong");

  // interrupt stays low while enable is clear
  property p_irq;
    @(posedge sys_clk_i) disable iff (srst_i)
    !irq_en_ff |=> !period_irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt forwarded while disabled");

  // reset values after release
  property p_rst;
    @(posedge sys_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> count_ff == 8'h00 && period_ff == 8'hff;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");

  // reserved modes hold the count
  property p_rsvd;
    @(posedge sys_clk_i) disable iff (srst_i)
    (mode_ff[4:3] == 2'b11 && !wr_count) |=> $stable(count_ff);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved mode moved count");

endmodule

//--- design/hltmc_params.svh
`ifndef HLTMC_PARAMS_SVH
`define HLTMC_PARAMS_SVH
// register offsets
`define HLTMC_OFS_COUNT 3'h0
`define HLTMC_OFS_PERIOD 3'h1
`define HLTMC_OFS_CTRL 3'h2
`define HLTMC_OFS_HLT 3'h3
`define HLTMC_OFS_SRC 3'h4
`define HLTMC_OFS_IRQEN 3'h5
`define HLTMC_OFS_STAT 3'h6
// control register fields
`define HLTMC_CTRL_ON 7
`define HLTMC_CTRL_PRE_HI 6
`define HLTMC_CTRL_PRE_LO 4
`define HLTMC_CTRL_POST_HI 3
`define HLTMC_CTRL_POST_LO 0
// reset values
`define HLTMC_RST_COUNT 8'h00
`define HLTMC_RST_PERIOD 8'hff
`define HLTMC_RST_CTRL 8'h00
`define HLTMC_RST_MODE 5'h00
// synchroniser depth in timer clocks
`define HLTMC_SYNC_STAGES 2
`endif

//--- design/hltmc_pkg.sv
package hltmc_pkg;
  // mode field upper bits
  typedef enum logic [1:0] {
    HLTMC_GRP_FREE = 2'b00,
    HLTMC_GRP_ONESHOT = 2'b01,
    HLTMC_GRP_MONO = 2'b10,
    HLTMC_GRP_RSVD = 2'b11
  } hltmc_grp_e;
  // register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hltmc_bus_s;
endpackage

//--- testbench/hltmc_ers_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side driver of the reset candidates
// ----------------------------------------
module hltmc_ers_model #(
  parameter int SRC_N = 8,
  parameter int SRC_W = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // requested level on the selected source
  input wire logic [SRC_W-1:0] src_sel_i,
  input wire logic level_i,
  // candidate sources
  output logic [SRC_N-1:0] ext_reset_input_o
);
  logic lvl_ff;
  logic [2:0] gap_ff;
  logic [SRC_N-1:0] noise_ff;

  // changes at least six clocks apart
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lvl_ff <= 1'b0;
      gap_ff <= 3'h0;
    end else if (level_i != lvl_ff && gap_ff == 3'h5) begin
      lvl_ff <= level_i;
      gap_ff <= 3'h0;
    end else if (gap_ff != 3'h5) begin
      gap_ff <= gap_ff + 3'h1;
    end
  end

  // unselected sources toggle every clock
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      noise_ff <= SRC_N'(8'h55);
    end else begin
      noise_ff <= ~noise_ff;
    end
  end

  // selected source carries the requested level
  always_comb begin
    ext_reset_input_o = noise_ff;
    ext_reset_input_o[src_sel_i] = lvl_ff;
  end
endmodule

//--- testbench/hw_limit_timer_mode_control_tb.sv
`timescale 1ns/1ps
module hw_limit_timer_mode_control_tb;
  import hltmc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  hltmc_bus_s bus = '0;
  logic freeze = 1'b0;
  logic lvl = 1'b0;
  logic [2:0] src = 3'h3;
  logic [7:0] rdata;
  logic [7:0] cnt;
  logic pulse;
  logic irq;
  logic [7:0] ext;
  int n_mismatch = 0;
  int checked = 0;

  // timer clock, 8 ns
  always #4 sys_clk = ~sys_clk;

  hltmc_mode_ctrl dut (
    .sys_clk_i(sys_clk),
    .srst_i(srst),
    .bus_i(bus),
    .rdata_o(rdata),
    .ext_reset_input_i(ext),
    .debug_freeze_i(freeze),
    .count_value_o(cnt),
    .postscaled_pulse_out_o(pulse),
    .period_irq_o(irq)
  );

  hltmc_ers_model model (
    .sys_clk_i(sys_clk),
    .srst_i(srst),
    .src_sel_i(src),
    .level_i(lvl),
    .ext_reset_input_o(ext)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic set_lvl(input logic v);
    @(posedge sys_clk);
    lvl <= v;
    step(12);
  endtask

  task automatic setup(input logic [7:0] m, input logic [7:0] p);
    wr(3'h2, 8'h00);
    step(4);
    wr(3'h3, m);
    wr(3'h1, p);
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h4, 8'h03);
  endtask

  task automatic n_pulse(input int n, output logic [7:0] k);
    k = 8'h00;
    repeat (n) begin
      step(1);
      if (pulse === 1'b1) k = k + 8'h01;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    rd(3'h0, d);
    chk("count", d, 8'h00);
    rd(3'h1, d);
    chk("period", d, 8'hff);
    rd(3'h3, d);
    chk("mode", d, 8'h00);
    wr(3'h7, 8'h5a);
    rd(3'h7, d);
    chk("unmapped", d, 8'h00);
  endtask

  task automatic t_swgate;
    logic [7:0] k;
    logic [7:0] c;
    setup(8'h00, 8'h02);
    wr(3'h2, 8'h80);
    for (int i = 0; i < 12 && cnt !== 8'h01; i++) step(1);
    step(1);
    chk("count", cnt, 8'h02);
    step(1);
    chk("count", cnt, 8'h00);
    step(1);
    chk("count", cnt, 8'h01);
    n_pulse(36, k);
    chk("pulses", k, 8'd12);
    wr(3'h2, 8'h82);
    step(4);
    n_pulse(36, k);
    chk("pulses", k, 8'd4);
    wr(3'h2, 8'h02);
    step(4);
    c = cnt;
    step(5);
    chk("held", cnt, c);
  endtask

  task automatic t_irq;
    logic [7:0] d;
    chk("irq", {7'h0, irq}, 8'h00);
    wr(3'h5, 8'h01);
    step(2);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(3'h6, 8'h01);
    step(2);
    chk("irq", {7'h0, irq}, 8'h00);
    rd(3'h6, d);
    chk("flag", {7'h0, d[0]}, 8'h00);
  endtask

  task automatic t_hwgate;
    logic [7:0] c;
    logic act;
    for (int m = 1; m <= 2; m++) begin
      act = (m == 1);
      setup(m[7:0], 8'hff);
      set_lvl(~act);
      wr(3'h2, 8'h80);
      step(4);
      c = cnt;
      step(6);
      chk("held", cnt, c);
      set_lvl(act);
      chk("moved", {7'h0, cnt != c}, 8'h01);
      @(posedge sys_clk);
      freeze <= 1'b1;
      set_lvl(~act);
      c = cnt;
      step(6);
      chk("moved", {7'h0, cnt != c}, 8'h01);
      @(posedge sys_clk);
      freeze <= 1'b0;
      step(6);
      c = cnt;
      step(6);
      chk("held", cnt, c);
    end
  endtask

  task automatic t_edge;
    logic st;
    for (int m = 4; m <= 5; m++) begin
      st = (m == 5);
      setup(m[7:0], 8'hff);
      set_lvl(st);
      wr(3'h2, 8'h80);
      step(20);
      set_lvl(~st);
      chk("cleared", {7'h0, cnt < 8'h0c}, 8'h01);
      set_lvl(st);
      chk("kept", {7'h0, cnt > 8'h0c}, 8'h01);
    end
  endtask

  task automatic t_oneshot;
    logic [7:0] d;
    setup(8'h08, 8'h03);
    wr(3'h2, 8'h80);
    step(16);
    chk("count", cnt, 8'h00);
    rd(3'h2, d);
    chk("on", {7'h0, d[7]}, 8'h00);
    rd(3'h6, d);
    chk("flag", {7'h0, d[0]}, 8'h01);
  endtask

  task automatic t_mono;
    logic [7:0] d;
    setup(8'h11, 8'h03);
    set_lvl(1'b0);
    wr(3'h2, 8'h80);
    step(8);
    chk("count", cnt, 8'h00);
    rd(3'h6, d);
    chk("flag", {7'h0, d[0]}, 8'h00);
    set_lvl(1'b1);
    chk("count", cnt, 8'h00);
    rd(3'h6, d);
    chk("flag", {7'h0, d[0]}, 8'h01);
    rd(3'h2, d);
    chk("on", {7'h0, d[7]}, 8'h01);
  endtask

  task automatic t_rsvd;
    logic [7:0] d;
    setup(8'h18, 8'h03);
    wr(3'h2, 8'h80);
    set_lvl(1'b1);
    set_lvl(1'b0);
    chk("count", cnt, 8'h00);
    rd(3'h6, d);
    chk("flag", {7'h0, d[0]}, 8'h00);
  endtask

  // level reset: low level clears (6), high level clears (7)
  task automatic t_lvl;
    logic st;
    for (int m = 6; m <= 7; m++) begin
      st = (m == 7);
      setup(m[7:0], 8'hff);
      set_lvl(st);
      wr(3'h2, 8'h80);
      step(12);
      chk("cleared", cnt, 8'h00);
      set_lvl(~st);
      chk("moved", {7'h0, cnt > 8'h04}, 8'h01);
      set_lvl(st);
      chk("cleared", cnt, 8'h00);
    end
  endtask

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_swgate;
    t_irq;
    t_hwgate;
    t_edge;
    t_oneshot;
    t_mono;
    t_rsvd;
    t_lvl;
    final_report;
  end

  // watchdog against a hang
  initial begin
    #300000;
    n_mismatch++;
    final_report;
  end
endmodule
